// *** logic/target_ctl_defines.svh ***
// Constants for the target display and breaker close controller
`ifndef TARGET_CTL_DEFINES_SVH
`define TARGET_CTL_DEFINES_SVH
`define CLK_FREQ_HZ 250000000
`define ONE_SECOND_S 1
`define ONE_SECOND_CYCLES (`CLK_FREQ_HZ * `ONE_SECOND_S)
`define SEL_FRONT_PANEL 4'h0
`define SEL_MAX 4'h8
`define HEADING_EVERY 4'h8
`define GROUP_MIN 3'h1
`define GROUP_MAX 3'h6
`define DEFAULT_CFT_CYCLES 32'h0000_0100
`endif

// *** logic/target_ctl_pkg.sv ***
// Types shared by the target display and breaker close controller
package target_ctl_pkg;
	// Command codes presented by the serial command parser
	typedef enum logic [3:0]
	{
		CMD_NONE = 4'h0,
		CMD_TARGET = 4'h1,
		CMD_TARGET_RESET = 4'h2,
		CMD_TIME = 4'h3,
		CMD_TRIGGER = 4'h4,
		CMD_CLOSE = 4'h5,
		CMD_COPY = 4'h6,
		CMD_LEVEL2 = 4'h7
	} cmd_t;
	// Close dialogue states
	typedef enum logic [2:0]
	{
		CL_IDLE = 3'h0,
		CL_ASK1 = 3'h1,
		CL_ASK2 = 3'h2,
		CL_DRIVE = 3'h3
	} close_state_t;
	// Close outcome reports
	typedef enum logic [1:0]
	{
		RPT_NONE = 2'h0,
		RPT_CLOSED = 2'h1,
		RPT_OPEN = 2'h2,
		RPT_ABORTED = 2'h3
	} close_rpt_t;
endpackage

// *** logic/pulse_timer.sv ***
// Retriggerable one-shot timer used for the lamp test and alarm pulses
`timescale 1ns/1ps
module pulse_timer
#(
	parameter int CYCLES = 250000000
)
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	output logic active_out
);
	initial
	begin
		if (CYCLES < 1)
			$error("pulse_timer needs at least one cycle");
	end
	logic [31:0] count_ff; // Cycles left in the pulse
	logic [31:0] nxt_count;
	assign nxt_count = start_in ? 32'(CYCLES) : ((count_ff != 32'h0) ? count_ff - 32'h1 : 32'h0);
	assign active_out = (count_ff != 32'h0);
	// Count down after each start
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			count_ff <= 32'h0;
		else
			count_ff <= nxt_count;
	end
endmodule // pulse_timer

// *** logic/row_streamer.sv ***
// Emits repeated target readings with a heading every eighth row
`timescale 1ns/1ps
`include "target_ctl_defines.svh"
module row_streamer
	import target_ctl_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic [7:0] count_in,
	input wire logic [7:0] row_in,
	input wire logic ready_in,
	output logic valid_out,
	output logic heading_out,
	output logic [7:0] data_out,
	output logic busy_out
);
	logic [7:0] left_ff; // Readings still to send
	logic [3:0] rows_ff; // Rows since the last heading
	logic head_ff; // Heading due next
	logic [7:0] data_ff;
	logic fire;
	assign valid_out = (left_ff != 8'h0);
	assign busy_out = valid_out;
	assign heading_out = head_ff;
	assign data_out = data_ff;
	assign fire = valid_out && ready_in;
	// Heading first, then rows, heading again after every eighth row
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			left_ff <= 8'h0;
			rows_ff <= 4'h0;
			head_ff <= 1'b0;
			data_ff <= 8'h00;
		end
		else if (start_in)
		begin
			left_ff <= count_in;
			rows_ff <= 4'h0;
			head_ff <= 1'b1;
			data_ff <= row_in;
		end
		else if (fire)
		begin
			data_ff <= row_in;
			if (head_ff)
				head_ff <= 1'b0;
			else
			begin
				left_ff <= left_ff - 8'h1;
				rows_ff <= (rows_ff == `HEADING_EVERY - 4'h1) ? 4'h0 : rows_ff + 4'h1;
				head_ff <= (rows_ff == `HEADING_EVERY - 4'h1) && (left_ff != 8'h1);
			end
		end
	end
endmodule // row_streamer

// *** logic/target_display_close_control.sv ***
// Target LED selection, time set, trigger, breaker close and group copy control
// Operation
// - Power-up shows front panel targets
// - Selections zero to eight map LED rows
// - One shows asserted, zero deasserted
// - Repeat readings, heading every eighth row
// - Timed-out port message clears to zero
// - Reset button clears, one-second lamp test
// - Zero timeouts keep non-zero selection
// - Target reset command returns zero, clears
// - Time command loads hours minutes seconds
// - Time code input sets clock
// - Trigger records event, acknowledges, summarizes
// - Level two attempt pulses alarm second
// - Close needs jumper, open breaker, no trip
// - Close held until closed or timeout
// - Two yes answers; no aborts close
// - Report closed when status shows closed
// - Copy groups one through six
// - Copy clears event buffer
// - Copy to active group pulses alarm
`timescale 1ns/1ps
`include "target_ctl_defines.svh"
module target_display_close_control
	import target_ctl_pkg::*;
#(
	parameter int LAMP_CYCLES = `ONE_SECOND_CYCLES,
	parameter int ALARM_CYCLES = `ONE_SECOND_CYCLES
)
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Command parser side
	input wire logic cmd_valid_in,
	input wire logic [3:0] cmd_code_in,
	input wire logic sel_given_in,
	input wire logic [3:0] sel_in,
	input wire logic count_given_in,
	input wire logic [7:0] count_in,
	input wire logic answer_valid_in,
	input wire logic answer_yes_in,
	input wire logic [4:0] hours_in,
	input wire logic [5:0] minutes_in,
	input wire logic [5:0] seconds_in,
	input wire logic [2:0] copy_src_in,
	input wire logic [2:0] copy_dst_in,
	input wire logic [2:0] active_group_in,
	input wire logic [31:0] close_failure_timer,
	input wire logic [15:0] port_one_idle_timeout,
	input wire logic [15:0] port_two_idle_timeout,
	input wire logic auto_port_timed_out_in,
	input wire logic auto_msg_sent_in,
	input wire logic [15:0] auto_port_timeout_in,
	// Time code side
	input wire logic irig_valid_in,
	input wire logic [4:0] irig_hours_in,
	input wire logic [5:0] irig_minutes_in,
	input wire logic [5:0] irig_seconds_in,
	// Element rows
	input wire logic [7:0] front_targets_in,
	input wire logic [7:0] row1_in,
	input wire logic [7:0] row2_in,
	input wire logic [7:0] row3_in,
	input wire logic [7:0] row4_in,
	input wire logic [7:0] row5_in,
	input wire logic [7:0] row6_in,
	input wire logic [5:0] inputs_in,
	input wire logic [5:0] other_contacts_in,
	input wire logic trip_asserted_in,
	// Pins
	input wire logic reset_button_in,
	input wire logic breaker_cmd_enable_jumper,
	input wire logic breaker_closed_status_in,
	// Reading stream
	input wire logic stream_ready_in,
	output logic stream_valid_out,
	output logic stream_heading_out,
	output logic [7:0] stream_data_out,
	// Results
	output logic [7:0] target_led_out,
	output logic [3:0] target_select_cmd,
	output logic target_clear_out,
	output logic [7:0] cleared_row_out,
	output logic cmd_reject_out,
	output logic [4:0] tod_hours_out,
	output logic [5:0] tod_minutes_out,
	output logic [5:0] tod_seconds_out,
	output logic event_trigger_out,
	output logic triggered_ack_out,
	output logic summary_out,
	output logic close_contact_out,
	output logic [1:0] close_report_out,
	output logic close_prompt_out,
	output logic copy_go_out,
	output logic event_buffer_clear_out,
	output logic alarm_contact_out
);
	initial
	begin
		if (LAMP_CYCLES < 1 || ALARM_CYCLES < 1)
			$error("timer lengths must be positive");
	end
	// ----------------------------------------------------------------
	// Pin synchronisers (three flops, change accepted when two agree)
	// ----------------------------------------------------------------
	logic [2:0] btn_sync_ff; // Reset button chain
	logic [2:0] bkr_sync_ff; // Breaker status chain
	logic btn_ff; // Accepted button level
	logic bkr_ff; // Accepted breaker closed level
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			btn_sync_ff <= 3'h0;
			bkr_sync_ff <= 3'h0;
			btn_ff <= 1'b0;
			bkr_ff <= 1'b0;
		end
		else
		begin
			btn_sync_ff <= {btn_sync_ff[1:0], reset_button_in};
			bkr_sync_ff <= {bkr_sync_ff[1:0], breaker_closed_status_in};
			if (btn_sync_ff[1] == btn_sync_ff[2])
				btn_ff <= btn_sync_ff[2];
			if (bkr_sync_ff[1] == bkr_sync_ff[2])
				bkr_ff <= bkr_sync_ff[2];
		end
	end
	// Button press edge
	logic btn_prev_ff;
	logic button_press;
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			btn_prev_ff <= 1'b0;
		else
			btn_prev_ff <= btn_ff;
	end
	assign button_press = btn_ff && !btn_prev_ff;
	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire cmd_target = cmd_valid_in && (cmd_code_in == CMD_TARGET);
	wire cmd_tr = cmd_valid_in && (cmd_code_in == CMD_TARGET_RESET);
	wire cmd_time = cmd_valid_in && (cmd_code_in == CMD_TIME);
	wire cmd_trig = cmd_valid_in && (cmd_code_in == CMD_TRIGGER);
	wire cmd_close = cmd_valid_in && (cmd_code_in == CMD_CLOSE);
	wire cmd_copy = cmd_valid_in && (cmd_code_in == CMD_COPY);
	wire cmd_lvl2 = cmd_valid_in && (cmd_code_in == CMD_LEVEL2);
	// Count without selection, or selection out of range, is refused
	wire target_bad = cmd_target && ((count_given_in && !sel_given_in) || (sel_in > `SEL_MAX));
	wire target_ok = cmd_target && sel_given_in && !target_bad;
	wire grp_ok = (copy_src_in >= `GROUP_MIN) && (copy_src_in <= `GROUP_MAX)
		&& (copy_dst_in >= `GROUP_MIN) && (copy_dst_in <= `GROUP_MAX);
	wire copy_ok = cmd_copy && grp_ok;
	wire time_ok = cmd_time && (hours_in < 5'd24) && (minutes_in < 6'd60) && (seconds_in < 6'd60);
	// Automatic return to zero only when timeouts allow it
	wire timeouts_live = (port_one_idle_timeout != 16'h0) || (port_two_idle_timeout != 16'h0);
	wire auto_clear = auto_port_timed_out_in && auto_msg_sent_in && timeouts_live
		&& (auto_port_timeout_in != 16'h0);
	wire clear_now = auto_clear || cmd_tr || button_press;
	// ----------------------------------------------------------------
	// Display selection and LED mux
	// ----------------------------------------------------------------
	logic [3:0] sel_ff;
	logic [3:0] nxt_sel;
	assign nxt_sel = clear_now ? `SEL_FRONT_PANEL : (target_ok ? sel_in : sel_ff);
	// Selection register, zero from reset
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			sel_ff <= `SEL_FRONT_PANEL;
		else
			sel_ff <= nxt_sel;
	end
	assign target_select_cmd = sel_ff;
	// Front panel targets cleared on request (clear pulse; row before a target reset kept for report)
	wire [7:0] in_row = {{<<{inputs_in}}, 2'b00};
	wire [7:0] out_row = {alarm_contact_out, other_contacts_in[3:0], close_contact_out,
		trip_asserted_in, 1'b0};
	logic [7:0] sel_row;
	always_comb
	begin
		unique case (sel_ff)
			4'h0: sel_row = front_targets_in;
			4'h1: sel_row = row1_in;
			4'h2: sel_row = row2_in;
			4'h3: sel_row = row3_in;
			4'h4: sel_row = row4_in;
			4'h5: sel_row = row5_in;
			4'h6: sel_row = row6_in;
			4'h7: sel_row = in_row;
			4'h8: sel_row = out_row;
			default: sel_row = 8'h00;
		endcase
	end
	// Lamp test after a button press
	logic lamp_on;
	pulse_timer #(.CYCLES(LAMP_CYCLES)) u_lamp
	(
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.start_in(button_press),
		.active_out(lamp_on)
	);
	assign target_led_out = lamp_on ? 8'hFF : sel_row;
	assign target_clear_out = clear_now;
	// Reported row after a target reset
	logic [7:0] cleared_ff;
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			cleared_ff <= 8'h00;
		else if (cmd_tr)
			cleared_ff <= front_targets_in;
	end
	assign cleared_row_out = cleared_ff;
	// Reject flag
	logic reject_ff;
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			reject_ff <= 1'b0;
		else
			reject_ff <= target_bad || (cmd_copy && !grp_ok);
	end
	assign cmd_reject_out = reject_ff;
	// ----------------------------------------------------------------
	// Repeated readings
	// ----------------------------------------------------------------
	wire [7:0] reps = count_given_in ? count_in : 8'h01;
	row_streamer u_stream
	(
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.start_in(target_ok),
		.count_in(reps),
		.row_in(target_led_out),
		.ready_in(stream_ready_in),
		.valid_out(stream_valid_out),
		.heading_out(stream_heading_out),
		.data_out(stream_data_out),
		.busy_out()
	);
	// ----------------------------------------------------------------
	// Time of day
	// ----------------------------------------------------------------
	logic [4:0] hh_ff;
	logic [5:0] mm_ff;
	logic [5:0] ss_ff;
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			hh_ff <= 5'h00;
			mm_ff <= 6'h00;
			ss_ff <= 6'h00;
		end
		else if (time_ok)
		begin
			hh_ff <= hours_in;
			mm_ff <= minutes_in;
			ss_ff <= seconds_in;
		end
		else if (irig_valid_in)
		begin
			hh_ff <= irig_hours_in;
			mm_ff <= irig_minutes_in;
			ss_ff <= irig_seconds_in;
		end
	end
	assign tod_hours_out = hh_ff;
	assign tod_minutes_out = mm_ff;
	assign tod_seconds_out = ss_ff;
	// ----------------------------------------------------------------
	// Trigger: record, acknowledge, then summary
	// ----------------------------------------------------------------
	logic trig_ff;
	logic ack_ff;
	logic sum_ff;
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			trig_ff <= 1'b0;
			ack_ff <= 1'b0;
			sum_ff <= 1'b0;
		end
		else
		begin
			trig_ff <= cmd_trig;
			ack_ff <= trig_ff;
			sum_ff <= ack_ff;
		end
	end
	assign event_trigger_out = trig_ff;
	assign triggered_ack_out = ack_ff;
	assign summary_out = sum_ff;
	// ----------------------------------------------------------------
	// Breaker close dialogue
	// ----------------------------------------------------------------
	close_state_t cl_ff;
	close_state_t nxt_cl;
	logic [31:0] cft_ff; // Close failure countdown
	logic [1:0] rpt_ff;
	logic [1:0] nxt_rpt;
	wire permit = breaker_cmd_enable_jumper && !bkr_ff && !trip_asserted_in;
	always_comb
	begin
		nxt_cl = cl_ff;
		nxt_rpt = RPT_NONE;
		unique case (cl_ff)
			CL_IDLE:
				if (cmd_close)
					nxt_cl = CL_ASK1;
			CL_ASK1:
				if (answer_valid_in)
				begin
					nxt_cl = answer_yes_in ? CL_ASK2 : CL_IDLE;
					if (!answer_yes_in)
						nxt_rpt = RPT_ABORTED;
				end
			CL_ASK2:
				if (answer_valid_in)
				begin
					if (!answer_yes_in)
					begin
						nxt_cl = CL_IDLE;
						nxt_rpt = RPT_ABORTED;
					end
					else if (bkr_ff)
					begin
						nxt_cl = CL_IDLE;
						nxt_rpt = RPT_CLOSED;
					end
					else if (permit)
						nxt_cl = CL_DRIVE;
					else
					begin
						nxt_cl = CL_IDLE;
						nxt_rpt = RPT_OPEN;
					end
				end
			CL_DRIVE:
				if (bkr_ff)
				begin
					nxt_cl = CL_IDLE;
					nxt_rpt = RPT_CLOSED;
				end
				else if (cft_ff == 32'h1)
				begin
					nxt_cl = CL_IDLE;
					nxt_rpt = RPT_OPEN;
				end
			default:
				nxt_cl = CL_IDLE;
		endcase
	end
	// Dialogue state, failure timer and report
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			cl_ff <= CL_IDLE;
			cft_ff <= 32'h0;
			rpt_ff <= RPT_NONE;
		end
		else
		begin
			cl_ff <= nxt_cl;
			rpt_ff <= nxt_rpt;
			if (cl_ff != CL_DRIVE && nxt_cl == CL_DRIVE)
				cft_ff <= (close_failure_timer == 32'h0) ? 32'h1 : close_failure_timer;
			else if (cft_ff != 32'h0)
				cft_ff <= cft_ff - 32'h1;
		end
	end
	assign close_contact_out = (cl_ff == CL_DRIVE);
	assign close_report_out = rpt_ff;
	assign close_prompt_out = (cl_ff == CL_ASK1) || (cl_ff == CL_ASK2);
	// ----------------------------------------------------------------
	// Group copy and alarm
	// ----------------------------------------------------------------
	logic copy_ff;
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			copy_ff <= 1'b0;
		else
			copy_ff <= copy_ok;
	end
	assign copy_go_out = copy_ff;
	assign event_buffer_clear_out = copy_ff;
	wire alarm_start = cmd_lvl2 || (copy_ok && (copy_dst_in == active_group_in));
	pulse_timer #(.CYCLES(ALARM_CYCLES)) u_alarm
	(
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.start_in(alarm_start),
		.active_out(alarm_contact_out)
	);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_reject_keeps_sel;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(target_bad && !clear_now) |=> (sel_ff == $past(sel_ff));
	endproperty
	a_reject_keeps_sel: assert property (p_reject_keeps_sel) else $error("bad select changed");
	property p_clear_zero;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		clear_now |=> (sel_ff == 4'h0);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("select not zeroed");
	property p_lamp;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		button_press |=> (target_led_out == 8'hFF) [*8];
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp test missing");
	property p_close_permit;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(close_contact_out) |-> $past(permit);
	endproperty
	a_close_permit: assert property (p_close_permit) else $error("close without permit");
	property p_close_drop;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(close_contact_out && bkr_ff) |=> !close_contact_out;
	endproperty
	a_close_drop: assert property (p_close_drop) else $error("close held after closure");
	property p_abort;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(close_prompt_out && answer_valid_in && !answer_yes_in)
			|=> (rpt_ff == RPT_ABORTED) && !close_prompt_out;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_trig_seq;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		cmd_trig |=> event_trigger_out ##1 triggered_ack_out ##1 summary_out;
	endproperty
	a_trig_seq: assert property (p_trig_seq) else $error("trigger order");
	property p_alarm;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		cmd_lvl2 |=> alarm_contact_out [*8];
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not pulsed");
	c_close: cover property (@(posedge sys_clk_in) $fell(close_contact_out));
	c_stream: cover property (@(posedge sys_clk_in) stream_heading_out && stream_valid_out);
	c_copy: cover property (@(posedge sys_clk_in) copy_go_out && alarm_contact_out);
endmodule // target_display_close_control

// *** verification/breaker_model.sv ***
// Breaker status contact model that follows the close output
`timescale 1ns/1ps
module breaker_model
#(
	parameter int DELAY = 6
)
(
	input wire logic sys_clk_in,
	input wire logic close_in,
	input wire logic [1:0] mode_in,
	output logic closed_out
);
	// Cycles the close coil has been held energised
	int run_ff;
	// Mode 0 closes DELAY+1 cycles into the close pulse, 1 stays open, 2 is already closed
	always_ff @(posedge sys_clk_in)
	begin
		run_ff <= close_in ? run_ff + 1 : 0;
		closed_out <= (mode_in == 2'h2) | ((mode_in == 2'h0) & (closed_out | (run_ff >= DELAY)));
	end
endmodule // breaker_model

// *** verification/target_display_close_control_tb.sv ***
// Self-checking bench for the target display and breaker close controller
`timescale 1ns/1ps
module target_display_close_control_tb;
	import target_ctl_pkg::*;
	// Close case: breaker mode, jumper, trip, answers, contact now, contact later, report
	typedef struct packed {logic [1:0] m; logic j, t, a1, a2, c, h; logic [1:0] r;} case_t;
	logic sys_clk_in, rstn_in, cmd_valid_in, sel_given_in, count_given_in, answer_valid_in;
	logic answer_yes_in, auto_port_timed_out_in, auto_msg_sent_in, irig_valid_in, ok;
	logic trip_asserted_in, reset_button_in, breaker_cmd_enable_jumper, stream_ready_in;
	logic breaker_closed_status_in, stream_valid_out, stream_heading_out, cmd_reject_out;
	logic target_clear_out, event_trigger_out, triggered_ack_out, summary_out;
	logic close_contact_out, close_prompt_out, copy_go_out, event_buffer_clear_out;
	logic alarm_contact_out;
	logic [3:0] cmd_code_in, sel_in, target_select_cmd;
	logic [7:0] count_in, stream_data_out, target_led_out, cleared_row_out;
	logic [4:0] hours_in, irig_hours_in, tod_hours_out;
	logic [5:0] minutes_in, seconds_in, irig_minutes_in, irig_seconds_in, inputs_in;
	logic [5:0] tod_minutes_out, tod_seconds_out, seen;
	logic [2:0] copy_src_in, copy_dst_in, active_group_in;
	logic [31:0] close_failure_timer;
	logic [15:0] port_one_idle_timeout, port_two_idle_timeout, auto_port_timeout_in;
	logic [1:0] close_report_out, mode, last_rpt;
	logic [7:0] rows [0:6];
	logic [7:0] exp_row [0:8];
	logic [9:0] cases [0:6];
	logic [5:0] cp [0:3];
	case_t k;
	int err_count, tests_run, j;

	target_display_close_control #(.LAMP_CYCLES(16), .ALARM_CYCLES(16)) i_target_display_close_control
	(
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in),
		.cmd_code_in(cmd_code_in), .sel_given_in(sel_given_in), .sel_in(sel_in),
		.count_given_in(count_given_in), .count_in(count_in), .answer_valid_in(answer_valid_in),
		.answer_yes_in(answer_yes_in), .hours_in(hours_in), .minutes_in(minutes_in),
		.seconds_in(seconds_in), .copy_src_in(copy_src_in), .copy_dst_in(copy_dst_in),
		.active_group_in(active_group_in), .close_failure_timer(close_failure_timer),
		.port_one_idle_timeout(port_one_idle_timeout),
		.port_two_idle_timeout(port_two_idle_timeout),
		.auto_port_timed_out_in(auto_port_timed_out_in), .auto_msg_sent_in(auto_msg_sent_in),
		.auto_port_timeout_in(auto_port_timeout_in), .irig_valid_in(irig_valid_in),
		.irig_hours_in(irig_hours_in), .irig_minutes_in(irig_minutes_in),
		.irig_seconds_in(irig_seconds_in), .front_targets_in(rows[0]), .row1_in(rows[1]),
		.row2_in(rows[2]), .row3_in(rows[3]), .row4_in(rows[4]), .row5_in(rows[5]),
		.row6_in(rows[6]), .inputs_in(inputs_in), .other_contacts_in(6'h00),
		.trip_asserted_in(trip_asserted_in), .reset_button_in(reset_button_in),
		.breaker_cmd_enable_jumper(breaker_cmd_enable_jumper),
		.breaker_closed_status_in(breaker_closed_status_in), .stream_ready_in(stream_ready_in),
		.stream_valid_out(stream_valid_out), .stream_heading_out(stream_heading_out),
		.stream_data_out(stream_data_out), .target_led_out(target_led_out),
		.target_select_cmd(target_select_cmd), .target_clear_out(target_clear_out),
		.cleared_row_out(cleared_row_out), .cmd_reject_out(cmd_reject_out),
		.tod_hours_out(tod_hours_out),
		.tod_minutes_out(tod_minutes_out), .tod_seconds_out(tod_seconds_out),
		.event_trigger_out(event_trigger_out), .triggered_ack_out(triggered_ack_out),
		.summary_out(summary_out), .close_contact_out(close_contact_out),
		.close_report_out(close_report_out), .close_prompt_out(close_prompt_out),
		.copy_go_out(copy_go_out), .event_buffer_clear_out(event_buffer_clear_out),
		.alarm_contact_out(alarm_contact_out)
	);

	breaker_model i_breaker_model
	(
		.sys_clk_in(sys_clk_in), .close_in(close_contact_out), .mode_in(mode),
		.closed_out(breaker_closed_status_in)
	);

	// 250 MHz clock
	initial
	begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	// Sticky record of pulse and contact outputs and of the last close report
	always @(posedge sys_clk_in)
	begin
		seen <= seen | {close_contact_out, alarm_contact_out, event_buffer_clear_out,
			copy_go_out, target_clear_out, cmd_reject_out};
		if (close_report_out != 2'h0)
			last_rpt <= close_report_out;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	task clr();
		seen = '0;
		last_rpt = 2'h0;
	endtask

	// One parser command, held for exactly one taking edge
	task cmd(input logic [3:0] c, input logic sg, input logic [3:0] s, input logic cg,
		input logic [7:0] n);
		@(negedge sys_clk_in);
		{cmd_valid_in, cmd_code_in, sel_given_in, sel_in, count_given_in, count_in} =
			{1'b1, c, sg, s, cg, n};
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b0;
	endtask

	// Operator answer to a close prompt
	task answer(input logic y);
		@(negedge sys_clk_in);
		{answer_valid_in, answer_yes_in} = {1'b1, y};
		@(negedge sys_clk_in);
		answer_valid_in = 1'b0;
		tick(2);
	endtask

	// Automatic message to a timed-out port, then the expected selection
	task auto_msg(input logic [15:0] p1, p2, apt, input logic [3:0] exp);
		cmd(CMD_TARGET, 1'b1, 4'h5, 1'b1, 8'h00);
		{port_one_idle_timeout, port_two_idle_timeout, auto_port_timeout_in} = {p1, p2, apt};
		clr();
		{auto_port_timed_out_in, auto_msg_sent_in} = 2'h3;
		tick(2);
		{auto_port_timed_out_in, auto_msg_sent_in} = 2'h0;
		tick(2);
		chk(target_select_cmd, exp);
		chk(seen[1], exp == 4'h0);
	endtask

	task conclude();
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial
	begin
		#100000;
		err_count++;
		conclude();
	end

	initial
	begin
		{rstn_in, cmd_valid_in, cmd_code_in, sel_given_in, sel_in, count_given_in, count_in} = '0;
		{answer_valid_in, answer_yes_in, hours_in, minutes_in, seconds_in} = '0;
		{irig_valid_in, irig_hours_in, irig_minutes_in, irig_seconds_in} = '0;
		{copy_src_in, copy_dst_in, auto_port_timed_out_in, auto_msg_sent_in} = '0;
		{port_one_idle_timeout, port_two_idle_timeout, auto_port_timeout_in} = {3{16'h000F}};
		{reset_button_in, trip_asserted_in, breaker_cmd_enable_jumper, stream_ready_in} = 4'h3;
		close_failure_timer = 32'h0000_0028;
		{mode, active_group_in, inputs_in} = {2'h1, 3'h6, 6'h21};
		rows = '{8'h81, 8'h12, 8'h34, 8'hC3, 8'h5A, 8'hA5, 8'h3C};
		exp_row = '{8'h81, 8'h12, 8'h34, 8'hC3, 8'h5A, 8'hA5, 8'h3C, 8'h84, 8'h02};
		cases = '{10'h0B9, 10'h1BE, 10'h2B1, 10'h130, 10'h1F0, 10'h1A3, 10'h193};
		cp = '{6'h26, 6'h31, 6'h03, 6'h17};
		err_count = 0;
		tests_run = 0;
		repeat (8) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		chk(target_select_cmd, 4'h0);
		chk(target_led_out, exp_row[0]);
		// Every selection, then one past the last
		trip_asserted_in = 1'b1;
		for (int n = 0; n < 10; n++)
		begin
			clr();
			cmd(CMD_TARGET, 1'b1, 4'(n), 1'b1, 8'h00);
			tick(2);
			chk(target_select_cmd, (n > 8) ? 8 : n);
			chk(target_led_out, exp_row[(n > 8) ? 8 : n]);
			chk(seen[0], n > 8);
		end
		trip_asserted_in = 1'b0;
		clr();
		cmd(CMD_TARGET, 1'b0, 4'h2, 1'b1, 8'h03);
		tick(2);
		chk({target_select_cmd, seen[0]}, {4'h8, 1'b1});
		// Ten readings with the sink stalling every third cycle
		cmd(CMD_TARGET, 1'b1, 4'h3, 1'b1, 8'h0A);
		j = 0;
		for (int i = 0; i < 90 && j < 12; i++)
		begin
			stream_ready_in = (i % 3 != 0);
			#1;
			if (stream_valid_out === 1'b1 && stream_ready_in)
			begin
				chk(stream_heading_out, j % 9 == 0);
				if (j % 9 != 0)
					chk(stream_data_out, 8'hC3);
				j++;
			end
			@(negedge sys_clk_in);
		end
		stream_ready_in = 1'b1;
		tick(4);
		chk({j, stream_valid_out}, {12, 1'b0});
		auto_msg(16'h000F, 16'h0000, 16'h000F, 4'h0);
		auto_msg(16'h000F, 16'h000F, 16'h0000, 4'h5);
		auto_msg(16'h0000, 16'h0000, 16'h000F, 4'h5);
		clr();
		reset_button_in = 1'b1;
		tick(2);
		reset_button_in = 1'b0;
		tick(6);
		chk({target_led_out, seen[1]}, {8'hFF, 1'b1});
		tick(30);
		chk(target_led_out == 8'hFF, 1'b0);
		cmd(CMD_TARGET, 1'b1, 4'h4, 1'b1, 8'h00);
		clr();
		cmd(CMD_TARGET_RESET, 1'b0, 4'h0, 1'b0, 8'h00);
		tick(2);
		chk({target_select_cmd, seen[1]}, {4'h0, 1'b1});
		chk(cleared_row_out, 8'h81);
		{hours_in, minutes_in, seconds_in} = {5'h17, 6'h1E, 6'h00};
		cmd(CMD_TIME, 1'b0, 4'h0, 1'b0, 8'h00);
		tick(2);
		chk({tod_hours_out, tod_minutes_out, tod_seconds_out}, {5'h17, 6'h1E, 6'h00});
		{irig_valid_in, irig_hours_in, irig_minutes_in, irig_seconds_in} = {1'b1, 17'h0_2083};
		tick(1);
		irig_valid_in = 1'b0;
		tick(2);
		chk({tod_hours_out, tod_minutes_out, tod_seconds_out}, 17'h0_2083);
		cmd(CMD_TRIGGER, 1'b0, 4'h0, 1'b0, 8'h00);
		for (int i = 0; i < 6 && event_trigger_out !== 1'b1; i++)
			tick(1);
		chk({event_trigger_out, triggered_ack_out, summary_out}, 3'h4);
		tick(1);
		chk({event_trigger_out, triggered_ack_out, summary_out}, 3'h2);
		tick(1);
		chk({event_trigger_out, triggered_ack_out, summary_out}, 3'h1);
		cmd(CMD_LEVEL2, 1'b0, 4'h0, 1'b0, 8'h00);
		tick(4);
		chk(alarm_contact_out, 1'b1);
		tick(30);
		chk(alarm_contact_out, 1'b0);
		// Copies: two legal, one bad source, one bad destination
		for (int i = 0; i < 4; i++)
		begin
			{copy_src_in, copy_dst_in} = cp[i];
			ok = (cp[i][5:3] inside {[1:6]}) && (cp[i][2:0] inside {[1:6]});
			clr();
			cmd(CMD_COPY, 1'b0, 4'h0, 1'b0, 8'h00);
			tick(4);
			chk({seen[3], seen[2], seen[0]}, {ok, ok, !ok});
			chk(seen[4], ok && cp[i][2:0] == 3'h6);
			tick(24);
		end
		// Close dialogues across breaker modes, permits and answers
		for (int i = 0; i < 7; i++)
		begin
			k = cases[i];
			{mode, breaker_cmd_enable_jumper, trip_asserted_in} = {k.m, k.j, k.t};
			tick(8);
			clr();
			cmd(CMD_CLOSE, 1'b0, 4'h0, 1'b0, 8'h00);
			tick(2);
			chk(close_prompt_out, 1'b1);
			answer(k.a1);
			if (k.a1)
				answer(k.a2);
			tick(1);
			chk(close_contact_out, k.c);
			tick(15);
			chk(close_contact_out, k.h);
			tick(60);
			chk({seen[5], close_contact_out}, {k.c, 1'b0});
			if (k.r != RPT_NONE)
				chk(last_rpt, k.r);
		end
		conclude();
	end
endmodule // target_display_close_control_tb
